// ===== tb_timer_pair_io_routing.sv
`timescale 1ns/1ps
module tb_timer_pair_io_routing;
	import tpr_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic es = 1'b0, ep = 1'b0, os = 1'b0, op = 1'b0;
	logic [2:0] level_cmd = 3'h0;
	logic [31:0] rdata;
	logic ep_out, ep_oe, op_out, op_oe, ew, ow, ci, cto, esi, ext_count_clock, est, emw, osi, ost;
	int fail_count = 0;
	int checked = 0;
	tpr_far_model far (.clk(clk), .reset(reset), .level_cmd(level_cmd),
		.even_waveform_out(ew), .odd_waveform_out(ow), .chain_trigger_in(ci));
	tpr_io_routing dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .even_primary_io_pin_in(ep), .even_secondary_io_pin_in(es),
		.odd_primary_io_pin_in(op), .odd_secondary_io_pin_in(os),
		.even_primary_io_pin_out(ep_out), .even_primary_io_pin_oe(ep_oe),
		.odd_primary_io_pin_out(op_out), .odd_primary_io_pin_oe(op_oe),
		.even_waveform_out(ew), .odd_waveform_out(ow), .chain_trigger_in(ci),
		.chain_trigger_out(cto), .even_shared_input(esi), .even_ext_count_clock(ext_count_clock),
		.even_ext_start_trigger(est), .even_measured_waveform(emw),
		.odd_shared_input(osi), .odd_stop_trigger(ost));
	initial begin
		forever #5 clk = ~clk;
	end
	// ----------
	// Shared tasks
	// ----------
	task automatic stop_test();
		$display("fail_count=%0d checked=%0d", fail_count, checked);
		if (fail_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd_reg
	// Pins and far-side levels {es, ep, os, op, ew, ow, ci}, then settle
	task automatic apply(input logic [6:0] v);
		@(posedge clk);
		{es, ep, os, op, level_cmd} <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask : apply
	// ----------
	// Scenarios
	// ----------
	task automatic mode1_test();
		wr_reg(TPR_IO_SELECT_OFS, 32'h1);
		for (int i = 0; i < 16; i++) begin
			apply({i[3:0], ~i[0], i[2], i[1]}); // odd primary only ever an input
			chk(ext_count_clock, es);
			chk(est, op);
			chk(emw, os);
			chk({ep_oe, ep_out, op_oe}, {1'b1, ew, 1'b0});
			chk({esi, osi, ost}, 3'h1);
		end
	endtask : mode1_test
	task automatic mode2_test();
		wr_reg(TPR_IO_SELECT_OFS, 32'h2);
		apply(7'h00);
		@(posedge clk);
		es <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(esi, 1'b0);
		@(posedge clk);
		#1;
		chk({esi, osi, cto}, 3'h7);
		apply(7'b1010_110);
		chk({ep_out, op_out, ep_oe, op_oe, cto}, 5'h1f);
		apply(7'b0010_001);
		chk({esi, osi, cto}, 3'h0);
	endtask : mode2_test
	task automatic mode3_test();
		wr_reg(TPR_IO_SELECT_OFS, 32'h3);
		apply(7'b1010_011); // chain level already high from mode2, relayed to both shared inputs and chain out
		chk({esi, osi, cto, ep_out, op_out}, 5'h1d);
		apply(7'b1010_010);
		chk({esi, osi, cto}, 3'h0);
	endtask : mode3_test
	task automatic mode4_test();
		wr_reg(TPR_IO_SELECT_OFS, 32'h4);
		apply(7'b1010_110);
		chk({esi, osi, ost, cto}, 4'hf);
		apply(7'b1010_001);
		chk({esi, osi, ost, cto}, 4'h8);
		rd_reg(TPR_STATUS_OFS, 32'h0000000e);
	endtask : mode4_test
	task automatic reg_test();
		wr_reg(TPR_IO_SELECT_OFS, 32'h9);
		rd_reg(TPR_IO_SELECT_OFS, 32'h4);
		rd_reg(4'h8, 32'h0);
	endtask : reg_test
	task automatic other_modes_test();
		wr_reg(TPR_IO_SELECT_OFS, 32'h0);
		apply(7'b1010_110);
		chk({esi, osi, ost, cto, op_out}, 5'h1d);
		wr_reg(TPR_IO_SELECT_OFS, 32'h6);
		apply(7'b1010_100);
		chk({esi, osi, ost, cto, op_out}, 5'h0e);
		wr_reg(TPR_IO_SELECT_OFS, 32'h7);
		apply(7'b1010_001);
		chk({esi, osi, ost, cto, op_out}, 5'h14);
		wr_reg(TPR_IO_SELECT_OFS, 32'h8);
		apply(7'b1010_001);
		chk({esi, osi, ost, cto, op_out}, 5'h1e);
		wr_reg(TPR_IO_SELECT_OFS, 32'h5);
		apply(7'b1010_111);
		chk({esi, osi, ost, cto, op_out}, 5'h05);
	endtask : other_modes_test
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd_reg(TPR_IO_SELECT_OFS, 32'h0);
		chk({ep_oe, op_oe, ost}, 3'h7);
		mode1_test();
		mode2_test();
		mode3_test();
		mode4_test();
		reg_test();
		other_modes_test();
		stop_test();
	end
endmodule : tb_timer_pair_io_routing

// ===== tpr_far_model.sv
`timescale 1ns/1ps
// ----------
// Timer cores and lower pair
// ----------
module tpr_far_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] level_cmd,
	output logic even_waveform_out,
	output logic odd_waveform_out,
	output logic chain_trigger_in
);
	// Levels move just after the edge, like clocked timer outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{even_waveform_out, odd_waveform_out, chain_trigger_in} <= 3'h0;
		end else begin
			{even_waveform_out, odd_waveform_out, chain_trigger_in} <= level_cmd;
		end
	end
endmodule : tpr_far_model

// ===== tpr_io_routing.sv
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module tpr_io_routing (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic even_primary_io_pin_in,
	input wire logic even_secondary_io_pin_in,
	input wire logic odd_primary_io_pin_in,
	input wire logic odd_secondary_io_pin_in,
	output logic even_primary_io_pin_out,
	output logic even_primary_io_pin_oe,
	output logic odd_primary_io_pin_out,
	output logic odd_primary_io_pin_oe,
	input wire logic even_waveform_out,
	input wire logic odd_waveform_out,
	input wire logic chain_trigger_in,
	output logic chain_trigger_out,
	output logic even_shared_input,
	output logic even_ext_count_clock,
	output logic even_ext_start_trigger,
	output logic even_measured_waveform,
	output logic odd_shared_input,
	output logic odd_stop_trigger
);
	import tpr_pkg::*;
	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	tpr_mode_t mode;
	tpr_mode_t next_mode;
	logic [31:0] next_rdata;
	logic sync_sec;
	always_comb begin
		next_mode = mode;
		next_rdata = 32'h0;
		if (wr && addr == TPR_IO_SELECT_OFS) begin
			case (wdata[3:0])
				4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
					next_mode = tpr_mode_t'(wdata[3:0]);
				end
				default: begin
					next_mode = mode;
				end
			endcase
		end
		if (rd) begin
			case (addr)
				TPR_IO_SELECT_OFS: begin
					next_rdata = {28'h0, mode};
				end
				TPR_STATUS_OFS: begin
					next_rdata = {27'h0, chain_trigger_out, odd_primary_io_pin_oe,
						even_primary_io_pin_oe, sync_sec, odd_stop_trigger};
				end
				default: begin
					next_rdata = 32'h0;
				end
			endcase
		end
	end
	// ------------------------------------------------------------
	// Synchroniser for the shared pin
	// ------------------------------------------------------------
	tpr_sync u_sync (
		.clk(clk),
		.reset(reset),
		.din(even_secondary_io_pin_in),
		.dout(sync_sec)
	);
	// ------------------------------------------------------------
	// Routing
	// ------------------------------------------------------------
	logic next_ep_out, next_ep_oe, next_op_out, next_op_oe, next_chain;
	logic next_esh, next_eck, next_etg, next_emw, next_osh, next_ostop;
	always_comb begin
		next_ep_out = even_waveform_out;
		next_ep_oe = 1'b1;
		next_op_out = odd_waveform_out;
		next_op_oe = 1'b1;
		next_chain = 1'b0;
		next_esh = 1'b0;
		next_eck = 1'b0;
		next_etg = 1'b0;
		next_emw = 1'b0;
		next_osh = 1'b0;
		next_ostop = 1'b1;
		case (mode)
			TPR_MODE0: begin
				next_esh = even_secondary_io_pin_in;
				next_osh = odd_secondary_io_pin_in;
			end
			TPR_MODE1: begin
				next_op_out = 1'b0;
				next_op_oe = 1'b0;
				next_eck = even_secondary_io_pin_in;
				next_etg = odd_primary_io_pin_in;
				next_emw = odd_secondary_io_pin_in;
			end
			TPR_MODE2: begin
				next_esh = sync_sec;
				next_osh = sync_sec;
				next_chain = sync_sec;
			end
			TPR_MODE3, TPR_MODE8: begin
				next_esh = chain_trigger_in;
				next_osh = chain_trigger_in;
				next_chain = chain_trigger_in;
			end
			TPR_MODE4: begin
				next_esh = even_secondary_io_pin_in;
				next_osh = even_waveform_out;
				next_ostop = even_waveform_out;
				next_chain = even_waveform_out;
			end
			TPR_MODE6: begin
				next_osh = even_waveform_out;
				next_ostop = even_waveform_out;
				next_chain = even_waveform_out;
			end
			TPR_MODE7: begin
				next_esh = even_secondary_io_pin_in;
				next_osh = even_waveform_out;
				next_chain = even_waveform_out;
			end
			default: begin
				next_esh = 1'b0;
			end
		endcase
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode <= tpr_mode_t'(TPR_MODE_RST);
			rdata <= 32'h0;
			even_primary_io_pin_out <= 1'b0;
			even_primary_io_pin_oe <= 1'b0;
			odd_primary_io_pin_out <= 1'b0;
			odd_primary_io_pin_oe <= 1'b0;
			chain_trigger_out <= 1'b0;
			even_shared_input <= 1'b0;
			even_ext_count_clock <= 1'b0;
			even_ext_start_trigger <= 1'b0;
			even_measured_waveform <= 1'b0;
			odd_shared_input <= 1'b0;
			odd_stop_trigger <= 1'b1;
		end else begin
			mode <= next_mode;
			rdata <= next_rdata;
			even_primary_io_pin_out <= next_ep_out;
			even_primary_io_pin_oe <= next_ep_oe;
			odd_primary_io_pin_out <= next_op_out;
			odd_primary_io_pin_oe <= next_op_oe;
			chain_trigger_out <= next_chain;
			even_shared_input <= next_esh;
			even_ext_count_clock <= next_eck;
			even_ext_start_trigger <= next_etg;
			even_measured_waveform <= next_emw;
			odd_shared_input <= next_osh;
			odd_stop_trigger <= next_ostop;
		end
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_mode1_clk;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE1 ##1 mode == TPR_MODE1 |->
			even_ext_count_clock == $past(even_secondary_io_pin_in);
	endproperty
	a_mode1_clk: assert property (p_mode1_clk) else $error("mode1 clock wrong");
	property p_mode1_trg;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE1 |=> even_ext_start_trigger == $past(odd_primary_io_pin_in)
			&& !odd_primary_io_pin_oe;
	endproperty
	a_mode1_trg: assert property (p_mode1_trg) else $error("mode1 trigger wrong");
	property p_mode1_mw;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE1 |=> even_measured_waveform == $past(odd_secondary_io_pin_in);
	endproperty
	a_mode1_mw: assert property (p_mode1_mw) else $error("mode1 waveform wrong");
	property p_mode2_sync;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE2 [*4] |-> odd_shared_input == $past(even_secondary_io_pin_in, 3)
			&& even_shared_input == odd_shared_input;
	endproperty
	a_mode2_sync: assert property (p_mode2_sync) else $error("mode2 sync wrong");
	property p_mode2_chain;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE2 |=> chain_trigger_out == even_shared_input;
	endproperty
	a_mode2_chain: assert property (p_mode2_chain) else $error("mode2 chain wrong");
	property p_mode3_relay;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE3 |=> chain_trigger_out == $past(chain_trigger_in)
			&& odd_shared_input == $past(chain_trigger_in);
	endproperty
	a_mode3_relay: assert property (p_mode3_relay) else $error("mode3 relay wrong");
	property p_mode4_stop;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE4 |=> odd_stop_trigger == $past(even_waveform_out)
			&& chain_trigger_out == odd_stop_trigger;
	endproperty
	a_mode4_stop: assert property (p_mode4_stop) else $error("mode4 stop wrong");
	property p_out_pins;
		@(posedge clk) disable iff (reset)
		(mode inside {TPR_MODE2, TPR_MODE3, TPR_MODE4}) |=>
			odd_primary_io_pin_out == $past(odd_waveform_out) && odd_primary_io_pin_oe;
	endproperty
	a_out_pins: assert property (p_out_pins) else $error("output pin wrong");
	property p_mode1_even_pin;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE1 |=>
			even_primary_io_pin_out == $past(even_waveform_out) && even_primary_io_pin_oe;
	endproperty
	a_mode1_even_pin: assert property (p_mode1_even_pin) else $error("mode1 pin");
	property p_mode1_no_shared;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE1 |=>
			!even_shared_input && !odd_shared_input;
	endproperty
	a_mode1_no_shared: assert property (p_mode1_no_shared) else $error("mode1 shared");
	property p_ext_only_mode1;
		@(posedge clk) disable iff (reset)
		mode != TPR_MODE1 |=>
			!even_ext_count_clock && !even_ext_start_trigger && !even_measured_waveform;
	endproperty
	a_ext_only_mode1: assert property (p_ext_only_mode1) else $error("ext idle");
	property p_even_pin;
		@(posedge clk) disable iff (reset)
		(mode inside {TPR_MODE2, TPR_MODE3, TPR_MODE4}) |=>
			even_primary_io_pin_out == $past(even_waveform_out) && even_primary_io_pin_oe;
	endproperty
	a_even_pin: assert property (p_even_pin) else $error("even pin wrong");
	property p_mode3_even;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE3 |=>
			even_shared_input == $past(chain_trigger_in);
	endproperty
	a_mode3_even: assert property (p_mode3_even) else $error("mode3 even wrong");
	property p_mode4_even;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE4 |=>
			even_shared_input == $past(even_secondary_io_pin_in);
	endproperty
	a_mode4_even: assert property (p_mode4_even) else $error("mode4 even wrong");
	property p_mode4_start;
		@(posedge clk) disable iff (reset)
		mode == TPR_MODE4 |=>
			odd_shared_input == $past(even_waveform_out);
	endproperty
	a_mode4_start: assert property (p_mode4_start) else $error("mode4 start wrong");
	property p_stop_idle;
		@(posedge clk) disable iff (reset)
		!(mode inside {TPR_MODE4, TPR_MODE6}) |=>
			odd_stop_trigger;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop idle wrong");
	property p_mode_write;
		@(posedge clk) disable iff (reset)
		wr && addr == TPR_IO_SELECT_OFS && wdata[3:0] <= 4'h8 |=>
			mode == $past(wdata[3:0]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode write wrong");
	property p_mode_hold;
		@(posedge clk) disable iff (reset)
		!(wr && addr == TPR_IO_SELECT_OFS && wdata[3:0] <= 4'h8) |=>
			$stable(mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode hold wrong");
	property p_rdata_idle;
		@(posedge clk) disable iff (reset)
		!rd |=>
			rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata idle wrong");
	c_mode1: cover property (@(posedge clk) disable iff (reset) mode == TPR_MODE1);
	c_mode2: cover property (@(posedge clk) disable iff (reset) mode == TPR_MODE2 && sync_sec);
	c_mode3: cover property (@(posedge clk) disable iff (reset) mode == TPR_MODE3);
	c_mode4: cover property (@(posedge clk) disable iff (reset)
		mode == TPR_MODE4 && $fell(odd_stop_trigger));
endmodule : tpr_io_routing

// ===== tpr_pkg.sv
package tpr_pkg;
	// ------------------------------------------------------------
	// Mode encodings
	// ------------------------------------------------------------
	localparam int MODE_W = 4;
	typedef enum logic [3:0] {
		TPR_MODE0 = 4'h0,
		TPR_MODE1 = 4'h1,
		TPR_MODE2 = 4'h2,
		TPR_MODE3 = 4'h3,
		TPR_MODE4 = 4'h4,
		TPR_MODE5 = 4'h5,
		TPR_MODE6 = 4'h6,
		TPR_MODE7 = 4'h7,
		TPR_MODE8 = 4'h8
	} tpr_mode_t;
	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] TPR_IO_SELECT_OFS = 4'h0;
	localparam logic [3:0] TPR_STATUS_OFS = 4'h4;
	localparam logic [3:0] TPR_MODE_RST = 4'h0;
	localparam int TPR_SYNC_STAGES = 2;
endpackage : tpr_pkg

// ===== tpr_sync.sv
`timescale 1ns/1ps
module tpr_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic din,
	output logic dout
);
	import tpr_pkg::*;
	logic stage1;
	logic next_stage1;
	logic next_dout;
	always_comb begin
		next_stage1 = din;
		next_dout = stage1;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stage1 <= 1'b0;
			dout <= 1'b0;
		end else begin
			stage1 <= next_stage1;
			dout <= next_dout;
		end
	end
endmodule : tpr_sync
